// *** shared/rpcs_pkg.sv ***
// shared constants and types of the repeater port control core
package rpcs_pkg;
  // clock and bit times
  localparam int CLK_NS     = 40;
  localparam int BIT_NS_100 = 10;
  localparam int BIT_NS_10  = 100;
  // bit time is counted in tenths of a bit per clock
  localparam logic [7:0] TENTH_100 = 8'(CLK_NS * 10 / BIT_NS_100);
  localparam logic [7:0] TENTH_10  = 8'(CLK_NS * 10 / BIT_NS_10);
  // jabber and partition limits
  localparam int unsigned JAB_BITS        = 32'h0001_0000;
  localparam int          PART_CLEAN_BITS = 512;
  localparam logic [12:0] CLEAN_LIM       = 13'(PART_CLEAN_BITS * 10);
  localparam logic [6:0]  PART_LIM        = 7'h40;
  // indicator timing
  localparam int INDICATOR_SHIFT_CLOCK_NS = 400;
  localparam logic [3:0] SCK_CYC  = 4'(INDICATOR_SHIFT_CLOCK_NS / CLK_NS);
  localparam logic [3:0] SCK_HALF = 4'(INDICATOR_SHIFT_CLOCK_NS / CLK_NS / 2);
  localparam logic [4:0] LED_LAST = 5'h1f;
  localparam int BURST_US = 52400;
  localparam int UTIL_US  = 104800;
  localparam int BLINK_US = 838400;
  localparam int DARK_US  = 419200;
  localparam int unsigned BURST_CYC = BURST_US / CLK_NS * 1000;
  localparam logic [4:0] UTIL_BURSTS  = 5'(UTIL_US / BURST_US);
  localparam logic [4:0] BLINK_BURSTS = 5'(BLINK_US / BURST_US);
  localparam logic [4:0] DARK_BURSTS  = 5'(DARK_US / BURST_US);
  // utilisation thresholds in percent, index 0 lights first
  localparam logic [5:0][6:0] UTIL_PCT = {7'h3c, 7'h1e, 7'h0f, 7'h0a, 7'h05, 7'h01};
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_UTIL = 8'h08;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam int CTRL_MF0 = 4;
  localparam int CTRL_MF1 = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {RPT_IDLE, RPT_FWD, RPT_COLL, RPT_ONE_LEFT} rpcs_rpt_t;
  typedef enum logic [1:0] {PH_BLINK, PH_DARK, PH_NORMAL} rpcs_phase_t;
endpackage

// *** rtl/rpcs_arbiter.sv ***
// repeater state machine of one speed segment
`timescale 1ns/10ps
module rpcs_arbiter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] active,
  input  wire logic [7:0] member,
  output logic      [7:0] rx_gate,
  output logic      [7:0] tx_gate,
  output logic      [7:0] jam,
  output logic            coll
);
  rpcs_pkg::rpcs_rpt_t st_r;
  rpcs_pkg::rpcs_rpt_t st_nxt;
  logic [3:0]          n;

  always_comb begin
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n = n + {3'h0, active[k]};
    end
    st_nxt  = st_r;
    rx_gate = 8'h00;
    tx_gate = 8'h00;
    jam     = 8'h00;
    unique case (st_r)
      rpcs_pkg::RPT_IDLE, rpcs_pkg::RPT_FWD: begin
        st_nxt = (n == 4'h0) ? rpcs_pkg::RPT_IDLE :
                 (n == 4'h1) ? rpcs_pkg::RPT_FWD : rpcs_pkg::RPT_COLL;
      end
      rpcs_pkg::RPT_COLL, rpcs_pkg::RPT_ONE_LEFT: begin
        st_nxt = (n == 4'h0) ? rpcs_pkg::RPT_IDLE :
                 (n == 4'h1) ? rpcs_pkg::RPT_ONE_LEFT : rpcs_pkg::RPT_COLL;
      end
    endcase
    // gates follow the next state so the top register adds only one cycle
    unique case (st_nxt)
      rpcs_pkg::RPT_IDLE: rx_gate = 8'h00;
      rpcs_pkg::RPT_FWD: begin
        rx_gate = active;
        tx_gate = member & ~active;
      end
      rpcs_pkg::RPT_COLL: begin
        tx_gate = member;
        jam     = member;
      end
      rpcs_pkg::RPT_ONE_LEFT: begin
        tx_gate = member & ~active;
        jam     = member & ~active;
      end
    endcase
    coll = (st_nxt == rpcs_pkg::RPT_COLL) || (st_nxt == rpcs_pkg::RPT_ONE_LEFT);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= rpcs_pkg::RPT_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_one_left_jam: assert property (
    (st_r == rpcs_pkg::RPT_COLL && $onehot(active))
      |=> st_r == rpcs_pkg::RPT_ONE_LEFT && rx_gate == 8'h00)
    else $error("one port left not entered after collision");
  a_coll_sticky: assert property (
    (st_r == rpcs_pkg::RPT_ONE_LEFT && $onehot(active)) |-> coll && jam == (member & ~active))
    else $error("jam dropped before collision ceased");
endmodule // rpcs_arbiter

// *** rtl/rpcs_top.sv ***
// repeater port control core: gating, jabber, partition, indicators, axi4-lite
`timescale 1ns/10ps
module rpcs_top #(
  parameter int unsigned BURST_CYC = rpcs_pkg::BURST_CYC,
  parameter int unsigned JAB_BITS  = rpcs_pkg::JAB_BITS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_carrier,
  input  wire logic [7:0]  port_speed_100,
  output logic [7:0]       port_rx_gate,
  output logic [7:0]       port_tx_gate,
  output logic [7:0]       port_jam_bit,
  output logic             indicator_shift_clock,
  output logic             indicator_data_0,
  output logic             indicator_data_1
);
  localparam logic [23:0] JAB_LIM  = 24'(JAB_BITS * 10);
  localparam logic [23:0] BURST_LS = 24'(BURST_CYC - 1);
  localparam logic [39:0] UTIL_PER = 40'(rpcs_pkg::UTIL_BURSTS) * 40'(BURST_CYC);

  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    unique case (a)
      rpcs_pkg::REG_CTRL: reg_sel = 2'h0;
      rpcs_pkg::REG_STAT: reg_sel = 2'h1;
      rpcs_pkg::REG_UTIL: reg_sel = 2'h2;
      default:            reg_sel = 2'h3;
    endcase
  endfunction

  function automatic logic [5:0] util_code(input logic [31:0] busy);
    for (int k = 0; k < 6; k++) begin
      util_code[k] = !(40'(busy) * 40'h64 >= 40'(rpcs_pkg::UTIL_PCT[k]) * UTIL_PER);
    end
  endfunction

  // pin synchronisers; the second stage is read, and carq_r, a third carrier stage, marks the end of a carrier
  logic [7:0] car_m_r, car_r, carq_r, spd_m_r, spd_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      car_m_r <= 8'h00;
      car_r   <= 8'h00;
      carq_r  <= 8'h00;
      spd_m_r <= 8'h00;
      spd_r   <= 8'h00;
    end else begin
      car_m_r <= port_carrier;
      car_r   <= car_m_r;
      carq_r  <= car_r;
      spd_m_r <= port_speed_100;
      spd_r   <= spd_m_r;
    end
  end

  // segment arbitration
  logic [7:0] jab_v, part_v, act_v, act, mem10, mem100;
  logic [7:0] rx10, tx10, jm10, rx100, tx100, jm100;
  logic       coll10, coll100, tick;
  assign act    = car_r & ~jab_v & ~part_v;
  assign mem10  = ~spd_r & ~jab_v;
  assign mem100 = spd_r & ~jab_v;

  rpcs_arbiter u_arb10 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .active  (act & ~spd_r),
    .member  (mem10),
    .rx_gate (rx10),
    .tx_gate (tx10),
    .jam     (jm10),
    .coll    (coll10)
  );
  rpcs_arbiter u_arb100 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .active  (act & spd_r),
    .member  (mem100),
    .rx_gate (rx100),
    .tx_gate (tx100),
    .jam     (jm100),
    .coll    (coll100)
  );

  logic [7:0] rx_nxt, tx_nxt, jam_nxt;
  always_comb begin
    rx_nxt  = rx10 | rx100;
    tx_nxt  = tx10 | tx100;
    jam_nxt = (jm10 | jm100) & ~port_jam_bit;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_rx_gate <= 8'h00;
      port_tx_gate <= 8'h00;
      port_jam_bit <= 8'h00;
    end else begin
      port_rx_gate <= rx_nxt;
      port_tx_gate <= tx_nxt;
      port_jam_bit <= jam_nxt;
    end
  end

  // per-port jabber, partition and activity
  for (genvar i = 0; i < 8; i++) begin : g_port
    logic [23:0] jc_r, jc_nxt;
    logic [12:0] cl_r, cl_nxt;
    logic [6:0]  cc_r, cc_nxt;
    logic        jb_r, jb_nxt, pt_r, pt_nxt, hit_r, hit_nxt, ac_r, ac_nxt;
    logic [7:0]  inc;
    always_comb begin
      inc     = spd_r[i] ? rpcs_pkg::TENTH_100 : rpcs_pkg::TENTH_10;
      jc_nxt  = 24'h000000;
      jb_nxt  = 1'b0;
      cl_nxt  = cl_r;
      cc_nxt  = cc_r;
      pt_nxt  = pt_r;
      hit_nxt = hit_r;
      if (car_r[i]) begin
        jb_nxt  = jb_r | (jc_r >= JAB_LIM);
        jc_nxt  = jb_nxt ? jc_r : jc_r + 24'(inc);
        hit_nxt = hit_r | (spd_r[i] ? coll100 : coll10);
        if (cl_r < rpcs_pkg::CLEAN_LIM) begin
          cl_nxt = cl_r + 13'(inc);
        end
      end else if (carq_r[i]) begin
        hit_nxt = 1'b0;
        cl_nxt  = 13'h0000;
        if (hit_r) begin
          cc_nxt = (cc_r == rpcs_pkg::PART_LIM) ? cc_r : cc_r + 7'h01;
          pt_nxt = pt_r | (cc_nxt == rpcs_pkg::PART_LIM);
        end else if (cl_r >= rpcs_pkg::CLEAN_LIM) begin
          cc_nxt = 7'h00;
          pt_nxt = 1'b0;
        end
      end
      // a carrier in the burst cycle still counts: set wins over clear
      ac_nxt = car_r[i] | (ac_r & ~tick);
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        jc_r  <= 24'h000000;
        cl_r  <= 13'h0000;
        cc_r  <= 7'h00;
        jb_r  <= 1'b0;
        pt_r  <= 1'b0;
        hit_r <= 1'b0;
        ac_r  <= 1'b0;
      end else begin
        jc_r  <= jc_nxt;
        cl_r  <= cl_nxt;
        cc_r  <= cc_nxt;
        jb_r  <= jb_nxt;
        pt_r  <= pt_nxt;
        hit_r <= hit_nxt;
        ac_r  <= ac_nxt;
      end
    end
    assign jab_v[i]  = jb_r;
    assign part_v[i] = pt_r;
    assign act_v[i]  = ac_r;
  end

  // indicator timing, power-on sequence and utilisation
  rpcs_pkg::rpcs_phase_t ph_r, ph_nxt;
  logic [23:0] bc_r, bc_nxt;
  logic [4:0]  pc_r, pc_nxt, ub_r, ub_nxt, bi_r, bi_nxt;
  logic [3:0]  sc_r, sc_nxt;
  logic [31:0] b10_r, b10_nxt, b100_r, b100_nxt, sd0_r, sd0_nxt, sd1_r, sd1_nxt;
  logic [5:0]  u10_r, u10_nxt, u100_r, u100_nxt;
  logic        blink_r, blink_nxt, sh_r, sh_nxt, ck_nxt, o0_nxt, o1_nxt;
  logic        cs10_r, cs10_nxt, cs100_r, cs100_nxt;
  logic [5:0]  ctrl_r;
  assign tick = (bc_r == BURST_LS);

  always_comb begin
    bc_nxt    = tick ? 24'h000000 : bc_r + 24'h000001;
    ph_nxt    = ph_r;
    pc_nxt    = pc_r;
    ub_nxt    = ub_r;
    u10_nxt   = u10_r;
    u100_nxt  = u100_r;
    b10_nxt   = b10_r + {31'h0, |(car_r & mem10)};
    b100_nxt  = b100_r + {31'h0, |(car_r & mem100)};
    blink_nxt = blink_r ^ tick;
    cs10_nxt  = coll10 | (cs10_r & ~tick);
    cs100_nxt = coll100 | (cs100_r & ~tick);
    sh_nxt    = sh_r;
    bi_nxt    = bi_r;
    sc_nxt    = sc_r;
    sd0_nxt   = sd0_r;
    sd1_nxt   = sd1_r;
    ck_nxt    = indicator_shift_clock;
    o0_nxt    = indicator_data_0;
    o1_nxt    = indicator_data_1;
    if (tick) begin
      pc_nxt = pc_r + 5'h01;
      ub_nxt = (ub_r == rpcs_pkg::UTIL_BURSTS - 5'h01) ? 5'h00 : ub_r + 5'h01;
      if (ub_r == rpcs_pkg::UTIL_BURSTS - 5'h01) begin
        u10_nxt  = util_code(b10_r);
        u100_nxt = util_code(b100_r);
        b10_nxt  = 32'h0;
        b100_nxt = 32'h0;
      end
      unique case (ph_r)
        rpcs_pkg::PH_BLINK: begin
          if (pc_r == rpcs_pkg::BLINK_BURSTS - 5'h01) begin
            ph_nxt = rpcs_pkg::PH_DARK;
            pc_nxt = 5'h00;
          end
        end
        rpcs_pkg::PH_DARK: begin
          if (pc_r == rpcs_pkg::DARK_BURSTS - 5'h01) begin
            ph_nxt = rpcs_pkg::PH_NORMAL;
            pc_nxt = 5'h00;
          end
        end
        rpcs_pkg::PH_NORMAL: pc_nxt = 5'h00;
      endcase
      // frames are built low-active, slot 0 in the top bit
      unique case (ph_nxt)
        rpcs_pkg::PH_BLINK: begin
          sd0_nxt = {32{~blink_nxt}};
          sd1_nxt = {32{~blink_nxt}};
        end
        rpcs_pkg::PH_DARK: begin
          sd0_nxt = 32'hffff_ffff;
          sd1_nxt = 32'hffff_ffff;
        end
        rpcs_pkg::PH_NORMAL: begin
          sd0_nxt = {~ctrl_r[3:2], u10_r, ~ctrl_r[1:0], u100_r, ~act_v, 8'hff};
          sd1_nxt = {~jab_v, 8'hff, ~part_v, 8'hff};
        end
      endcase
      sh_nxt = 1'b1;
      bi_nxt = 5'h00;
      sc_nxt = 4'h0;
      ck_nxt = 1'b0;
      o0_nxt = sd0_nxt[31];
      o1_nxt = sd1_nxt[31];
    end else if (sh_r) begin
      sc_nxt = sc_r + 4'h1;
      if (sc_r == rpcs_pkg::SCK_HALF - 4'h1) begin
        ck_nxt = 1'b1;
      end
      if (sc_r == rpcs_pkg::SCK_CYC - 4'h1) begin
        sc_nxt  = 4'h0;
        ck_nxt  = 1'b0;
        bi_nxt  = bi_r + 5'h01;
        sd0_nxt = {sd0_r[30:0], 1'b1};
        sd1_nxt = {sd1_r[30:0], 1'b1};
        o0_nxt  = sd0_nxt[31];
        o1_nxt  = sd1_nxt[31];
        if (bi_r == rpcs_pkg::LED_LAST) begin
          sh_nxt = 1'b0;
        end
      end
    end
    if (!sh_nxt) begin
      unique case (ph_nxt)
        rpcs_pkg::PH_BLINK: begin
          o0_nxt = ~blink_nxt;
          o1_nxt = ~blink_nxt;
        end
        rpcs_pkg::PH_DARK: begin
          o0_nxt = 1'b1;
          o1_nxt = 1'b1;
        end
        rpcs_pkg::PH_NORMAL: begin
          // collision blinks so a busy segment is told apart from a memory fault
          o0_nxt = ~(ctrl_r[rpcs_pkg::CTRL_MF0] | (cs100_r & blink_nxt));
          o1_nxt = ~(ctrl_r[rpcs_pkg::CTRL_MF1] | (cs10_r & blink_nxt));
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_r  <= rpcs_pkg::PH_BLINK;
      bc_r  <= 24'h000000;
      pc_r  <= 5'h00;
      ub_r  <= 5'h00;
      bi_r  <= 5'h00;
      sc_r  <= 4'h0;
      b10_r <= 32'h0;
      b100_r <= 32'h0;
      sd0_r <= 32'hffff_ffff;
      sd1_r <= 32'hffff_ffff;
      u10_r <= 6'h3f;
      u100_r <= 6'h3f;
      blink_r <= 1'b0;
      sh_r  <= 1'b0;
      cs10_r <= 1'b0;
      cs100_r <= 1'b0;
      indicator_shift_clock <= 1'b0;
      indicator_data_0 <= 1'b1;
      indicator_data_1 <= 1'b1;
    end else begin
      ph_r  <= ph_nxt;
      bc_r  <= bc_nxt;
      pc_r  <= pc_nxt;
      ub_r  <= ub_nxt;
      bi_r  <= bi_nxt;
      sc_r  <= sc_nxt;
      b10_r <= b10_nxt;
      b100_r <= b100_nxt;
      sd0_r <= sd0_nxt;
      sd1_r <= sd1_nxt;
      u10_r <= u10_nxt;
      u100_r <= u100_nxt;
      blink_r <= blink_nxt;
      sh_r  <= sh_nxt;
      cs10_r <= cs10_nxt;
      cs100_r <= cs100_nxt;
      indicator_shift_clock <= ck_nxt;
      indicator_data_0 <= o0_nxt;
      indicator_data_1 <= o1_nxt;
    end
  end

  // axi4-lite slave: one write and one read in flight
  logic [5:0]  ctrl_nxt;
  logic [31:0] rd_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt, wsel, rsel;
  logic        awr_nxt, bv_nxt, arr_nxt, rv_nxt;
  always_comb begin
    wsel      = reg_sel(s_axi_awaddr);
    rsel      = reg_sel(s_axi_araddr);
    awr_nxt   = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
    bv_nxt    = s_axi_bvalid ? ~s_axi_bready : s_axi_awready;
    arr_nxt   = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    rv_nxt    = s_axi_rvalid ? ~s_axi_rready : s_axi_arready;
    ctrl_nxt  = ctrl_r;
    bresp_nxt = s_axi_bresp;
    rresp_nxt = s_axi_rresp;
    rd_nxt    = s_axi_rdata;
    if (s_axi_awready) begin
      bresp_nxt = (wsel == 2'h3) ? rpcs_pkg::RESP_DECERR : rpcs_pkg::RESP_OKAY;
      if (wsel == 2'h0 && s_axi_wstrb[0]) begin
        ctrl_nxt = s_axi_wdata[5:0];
      end
    end
    if (s_axi_arready) begin
      rresp_nxt = (rsel == 2'h3) ? rpcs_pkg::RESP_DECERR : rpcs_pkg::RESP_OKAY;
      unique case (rsel)
        2'h0: rd_nxt = {26'h0, ctrl_r};
        2'h1: rd_nxt = {8'h00, act_v, part_v, jab_v};
        2'h2: rd_nxt = {18'h0, u100_r, 2'h0, u10_r};
        2'h3: rd_nxt = 32'h0;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r        <= rpcs_pkg::CTRL_RST;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= rpcs_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= rpcs_pkg::RESP_OKAY;
      s_axi_rdata   <= 32'h0;
    end else begin
      ctrl_r        <= ctrl_nxt;
      s_axi_awready <= awr_nxt;
      s_axi_wready  <= awr_nxt;
      s_axi_bvalid  <= bv_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= arr_nxt;
      s_axi_rvalid  <= rv_nxt;
      s_axi_rresp   <= rresp_nxt;
      s_axi_rdata   <= rd_nxt;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_idle_gates_off: assert property (
    (car_r == 8'h00) |=> port_rx_gate == 8'h00 && port_tx_gate == 8'h00)
    else $error("gates open with no carrier");
  a_fwd_one_port: assert property (
    ($onehot(act) && $past(act) == 8'h00) |=> port_rx_gate == $past(act))
    else $error("receive gate not on the single carrying port");
  a_coll_all_tx: assert property (
    ($countones(act) > 1 && spd_r == 8'h00 && $stable(spd_r))
      |=> port_rx_gate == 8'h00 && port_tx_gate == $past(mem10))
    else $error("collision gating wrong");
  a_jab_set: assert property (
    (car_r[4] && g_port[4].jc_r >= JAB_LIM) |=> jab_v[4])
    else $error("jabber not flagged after limit");
  a_jab_block: assert property (
    (|jab_v) |=> ((port_rx_gate | port_tx_gate) & $past(jab_v)) == 8'h00)
    else $error("jabbered port still gated");
  a_jab_clear: assert property (
    (|(jab_v & ~car_r)) |=> ($past(jab_v & ~car_r) & jab_v) == 8'h00)
    else $error("jabber held after carrier drop");
  a_part_set: assert property (
    (!car_r[0] && carq_r[0] && g_port[0].hit_r && g_port[0].cc_r == 7'h3f) |=> part_v[0])
    else $error("port not isolated after 64 collisions");
  a_jam_alternate: assert property (
    port_jam_bit[0] |=> !port_jam_bit[0])
    else $error("jam pattern not alternating");
  a_sck_period: assert property (
    $rose(indicator_shift_clock) |=> indicator_shift_clock [*4] ##1 !indicator_shift_clock)
    else $error("shift clock high phase not 200 ns");
  a_data_stable: assert property (
    (indicator_shift_clock && $past(indicator_shift_clock))
      |-> $stable(indicator_data_0) && $stable(indicator_data_1))
    else $error("indicator data moved while shift clock high");
  a_dark_phase: assert property (
    (ph_r == rpcs_pkg::PH_DARK) |-> indicator_data_0 && indicator_data_1)
    else $error("indicator lit during dark phase");
endmodule // rpcs_top

// *** verification/rpcs_led_sink.sv ***
// external indicator shift registers of the repeater port control core
`timescale 1ns/10ps
module rpcs_led_sink (
  input  wire logic        indicator_shift_clock,
  input  wire logic        indicator_data_0,
  input  wire logic        indicator_data_1,
  output logic      [31:0] cap0,
  output logic      [31:0] cap1,
  output int               n_burst
);
  logic [31:0] sr0;
  logic [31:0] sr1;
  int          nb;
  initial begin
    {sr0, sr1, cap0, cap1} = '0;
    nb = 0;
    n_burst = 0;
  end
  // shift right so slot 0 ends in bit 0; no reset, the clock only runs in bursts
  always @(posedge indicator_shift_clock) begin
    sr0 = {indicator_data_0, sr0[31:1]};
    sr1 = {indicator_data_1, sr1[31:1]};
    nb = nb + 1;
    if (nb == 32) begin
      nb = 0;
      cap0 = sr0;
      cap1 = sr1;
      // non-blocking so a watcher of the count sees the captured words already
      n_burst <= n_burst + 1;
    end
  end
endmodule // rpcs_led_sink

// *** verification/tb.sv ***
// self-checking bench of the repeater port control core
`timescale 1ns/10ps
module tb;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = '0, araddr = '0, car = '0, rxg, txg, jam, j1, p, q;
  logic [7:0]  spd = 8'hff;
  logic [31:0] wdata = '0, rdat, v, cap0, cap1;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, blink0 = 0;
  logic        awready, wready, bvalid, arready, rvalid, sck, d0, d1;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  chip;
  int          n_burst, n, m, cyc = 0, n_mismatch = 0, check_count = 0;

  initial forever #20 aclk = ~aclk;

  // short burst spacing and jabber limit keep the run small
  rpcs_top #(.BURST_CYC(400), .JAB_BITS(1024)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_carrier(car), .port_speed_100(spd), .port_rx_gate(rxg), .port_tx_gate(txg),
    .port_jam_bit(jam), .indicator_shift_clock(sck), .indicator_data_0(d0),
    .indicator_data_1(d1));

  rpcs_led_sink i_sink (.indicator_shift_clock(sck), .indicator_data_0(d0),
    .indicator_data_1(d1), .cap0(cap0), .cap1(cap1), .n_burst(n_burst));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cy(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic cr(input logic [7:0] c, input int k);
    car <= c;
    cy(k);
  endtask

  task automatic gt(input logic [7:0] er, input logic [7:0] et);
    chk({16'h0, rxg, txg}, {16'h0, er, et});
  endtask

  // address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        r = bresp;
        done = 1;
      end
    end
    bready <= 0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        d = rdat;
        r = rresp;
        done = 1;
      end
    end
    rready <= 0;
    @(posedge aclk);
  endtask

  function automatic logic [31:0] ef(input logic [3:0] c);
    logic [31:0] e;
    e = '1;
    {e[9], e[8], e[1], e[0]} = ~{c[0], c[1], c[2], c[3]};
    return e;
  endfunction

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  always @(n_burst) begin
    if (n_burst <= 16 && cap0 === 32'h0) blink0 = 1;
    if (n_burst > 15 && n_burst <= 23) begin
      chk(cap0, '1);
      chk(cap1, '1);
    end
  end

  initial begin
    n = $urandom(85688);
    chip = 4'($urandom);
    cy(8);
    aresetn <= 1;
    cy(1);
    axr(8'h08, v, rs);
    chk({rs, v[29:0]}, {rpcs_pkg::RESP_OKAY, 30'h3f3f});
    axr(8'h0c, v, rs);
    chk({rs, v[29:0]}, {rpcs_pkg::RESP_DECERR, 30'h0});
    axw(8'h10, 32'hffff, rs);
    chk({30'h0, rs}, {30'h0, rpcs_pkg::RESP_DECERR});
    axw(8'h00, {28'h0, chip}, rs);
    axr(8'h00, v, rs);
    chk(v, {28'h0, chip});
    $display("register test done");
    // the 64th consecutive collision is the one that isolates
    repeat (63) begin
      cr(8'h03, 6);
      cr(8'h00, 6);
    end
    axr(8'h04, v, rs);
    chk(v & 32'hff00, 32'h0);
    cr(8'h03, 6);
    cr(8'h00, 6);
    axr(8'h04, v, rs);
    chk(v & 32'hff00, 32'h0300);
    cr(8'h01, 4);
    gt(8'h00, 8'h00);
    cr(8'h01, 146);
    cr(8'h00, 6);
    axr(8'h04, v, rs);
    chk(v & 32'hff00, 32'h0200);
    $display("isolation test done");
    repeat (6) begin
      n = 2 + $urandom % 6;
      m = 2 + (n - 1 + $urandom % 5) % 6;
      p = 8'(1 << n);
      q = 8'(1 << m);
      cr(8'h00, 4);
      chk({8'h0, jam, rxg, txg}, 32'h0);
      cr(p, 4);
      gt(p, ~p);
      cr(p | q, 4);
      gt(8'h00, 8'hff);
      j1 = jam;
      cy(1);
      chk({24'h0, j1 ^ jam}, 32'hff);
      cr(q, 4);
      gt(8'h00, ~q);
      j1 = jam;
      cy(1);
      chk({24'h0, j1 ^ jam}, {24'h0, ~q});
    end
    // the 10M segment gets a collision of its own
    spd <= 8'h00;
    cr(8'h0c, 6);
    gt(8'h00, 8'hff);
    cr(8'h00, 4);
    spd <= 8'hff;
    $display("gating test done");
    cr(8'h10, 270);
    axr(8'h04, v, rs);
    chk(v & 32'hff, 32'h10);
    cr(8'h30, 4);
    gt(8'h20, 8'hcf);
    cr(8'h20, 4);
    cr(8'h00, 4);
    axr(8'h04, v, rs);
    chk(v & 32'hff, 32'h0);
    $display("jabber test done");
    // half-duty traffic on one port spans three sampling windows
    repeat (12) begin
      cr(8'h04, 100);
      cr(8'h00, 100);
    end
    axr(8'h08, v, rs);
    chk(v, 32'h203f);
    $display("utilisation test done");
    while (n_burst < 25) cy(1);
    // a short packet between bursts must show as traffic in the next frame
    cr(p, 10);
    cr(8'h00, 2);
    while (n_burst < 26) cy(1);
    chk({31'h0, blink0}, 32'h1);
    chk(cap0, ef(chip) & ~(32'h1 << (23 - n)));
    chk(cap1, ~(32'h1 << 22));
    axw(8'h00, {26'h0, 2'h1, chip}, rs);
    cy(8);
    chk({30'h0, d1, d0}, 32'h2);
    $display("indicator test done");
    end_of_test();
  end
endmodule // tb
